// ### hdl/processor_feature_id.sv
// System-register read port for the processor feature identification words
`default_nettype none
module processor_feature_id (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    // Strap pin, asynchronous
    input  wire logic        cpu_if_disable_input,
    // Pipeline context
    input  wire logic [1:0]  current_exception_level,
    input  wire logic        hyp_enabled,
    input  wire logic        trap_general_exceptions_bit,
    input  wire logic        trap_id_group3_bit,
    // Read request
    input  wire logic        rd_req,
    input  wire logic [1:0]  rd_op0,
    input  wire logic [2:0]  rd_op1,
    input  wire logic [3:0]  rd_crn,
    input  wire logic [3:0]  rd_crm,
    input  wire logic [2:0]  rd_op2,
    // Answer
    output logic             rd_valid,
    output logic [63:0]      rd_data,
    output logic             rd_hit,
    output logic             rd_trap,
    output logic [1:0]       rd_trap_level,
    output logic [5:0]       rd_trap_class
);
    import feat_id_pkg::*;

    // =========================================================
    // State
    typedef struct packed {
        logic        dis_meta;
        logic        dis_sync;
        logic        valid;
        logic [63:0] data;
        logic        hit;
        logic        trap;
        logic [1:0]  trap_level;
        logic [5:0]  trap_class;
    } state_t;

    state_t st_r;
    state_t st_nxt;
    logic [63:0] pfr0_value;

    feat_value u_value (
        .cpu_if_disable (st_r.dis_sync),
        .value          (pfr0_value)
    );

    // Decodes the shared part of the register encoding
    function automatic logic group_match(input logic [1:0] op0,
                                         input logic [2:0] op1,
                                         input logic [3:0] crn,
                                         input logic [3:0] crm);
        group_match = (op0 == SEL_OP0) && (op1 == SEL_OP1) &&
                      (crn == SEL_CRN) && (crm == SEL_CRM);
    endfunction

    // =========================================================
    // Next state
    always_comb begin
        logic sel0;
        logic sel1;
        level_t lvl;
        sel0 = 1'b0;
        sel1 = 1'b0;
        lvl = level_t'(current_exception_level);
        st_nxt = st_r;
        st_nxt.dis_meta = cpu_if_disable_input;
        st_nxt.dis_sync = st_r.dis_meta;
        st_nxt.valid = rd_req;
        st_nxt.data = '0;
        st_nxt.hit = 1'b0;
        st_nxt.trap = 1'b0;
        st_nxt.trap_level = 2'h0;
        st_nxt.trap_class = 6'h00;
        if (rd_req) begin
            sel0 = group_match(rd_op0, rd_op1, rd_crn, rd_crm)
                   && (rd_op2 == SEL_OP2_PFR0);
            sel1 = group_match(rd_op0, rd_op1, rd_crn, rd_crm)
                   && (rd_op2 == SEL_OP2_PFR1);
        end
        // Nothing here is writable, a read changes no state
        if (sel0 || sel1) begin
            st_nxt.hit = 1'b1;
            unique case (lvl)
                LVL_USER: begin
                    st_nxt.trap = 1'b1;
                    st_nxt.trap_class = TRAP_CLASS;
                    st_nxt.trap_level = (hyp_enabled &&
                        trap_general_exceptions_bit) ? 2'h2 : 2'h1;
                end
                LVL_KERNEL: begin
                    if (hyp_enabled && trap_id_group3_bit) begin
                        st_nxt.trap = 1'b1;
                        st_nxt.trap_class = TRAP_CLASS;
                        st_nxt.trap_level = 2'h2;
                    end else begin
                        st_nxt.data = sel0 ? pfr0_value : PFR1_VALUE;
                    end
                end
                LVL_HYP, LVL_MON: begin
                    st_nxt.data = sel0 ? pfr0_value : PFR1_VALUE;
                end
            endcase
        end
        if (!nrst) begin
            st_nxt = '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        st_r <= st_nxt;
    end

    assign rd_valid      = st_r.valid;
    assign rd_data       = st_r.data;
    assign rd_hit        = st_r.hit;
    assign rd_trap       = st_r.trap;
    assign rd_trap_level = st_r.trap_level;
    assign rd_trap_class = st_r.trap_class;

    // =========================================================
    // Checks
    a_user_traps: assert property (@(posedge clk_sys) disable iff (!nrst)
        rd_req && current_exception_level == 2'h0 &&
        group_match(rd_op0, rd_op1, rd_crn, rd_crm) && rd_op2 == 3'h0
        |=> rd_trap && rd_trap_class == 6'h18 && rd_data == 64'h0)
        else $error("user read did not trap");
    a_kern_trap: assert property (@(posedge clk_sys) disable iff (!nrst)
        rd_req && current_exception_level == 2'h1 && hyp_enabled &&
        trap_id_group3_bit && rd_op2[2:1] == 2'h0 &&
        group_match(rd_op0, rd_op1, rd_crn, rd_crm)
        |=> rd_trap && rd_trap_level == 2'h2)
        else $error("kernel read did not trap to hypervisor");
    a_high_reads: assert property (@(posedge clk_sys) disable iff (!nrst)
        rd_req && current_exception_level[1] && rd_op2 == 3'h0 &&
        group_match(rd_op0, rd_op1, rd_crn, rd_crm)
        |=> !rd_trap && rd_data[51:28] == 24'h111112)
        else $error("high level read wrong");
    a_low_fields: assert property (@(posedge clk_sys) disable iff (!nrst)
        rd_valid && rd_hit && !rd_trap && rd_data != 64'h0
        |-> rd_data[23:0] == 24'h111111)
        else $error("low feature fields wrong");
    a_gic_off: assert property (@(posedge clk_sys) disable iff (!nrst)
        rd_valid && rd_data[51:48] == 4'h1 && $past(st_r.dis_sync)
        |-> rd_data[27:24] == 4'h0)
        else $error("interface field not zero while disabled");
    a_gic_on: assert property (@(posedge clk_sys) disable iff (!nrst)
        rd_valid && rd_data[51:48] == 4'h1 && !$past(st_r.dis_sync)
        |-> rd_data[27:24] == 4'h3)
        else $error("interface field not three while enabled");
    a_miss_quiet: assert property (@(posedge clk_sys) disable iff (!nrst)
        rd_req && rd_crm != 4'h4 |=> !rd_hit && !rd_trap)
        else $error("unmatched encoding answered");
    a_pfr1_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
        rd_req && rd_op2 == 3'h1 && current_exception_level == 2'h3 &&
        group_match(rd_op0, rd_op1, rd_crn, rd_crm)
        |=> rd_hit && rd_data == 64'h0)
        else $error("second register read wrong");

    // =========================================================
    // Field checks on every untrapped register 0 answer
    a_timing_field: assert property (@(posedge clk_sys) disable iff (!nrst)
        rd_valid && rd_hit && !rd_trap && rd_data != 64'h0
        |-> rd_data[51:48] == 4'h1)
        else $error("timing field wrong");

    a_actmon_field: assert property (@(posedge clk_sys) disable iff (!nrst)
        rd_valid && rd_hit && !rd_trap && rd_data != 64'h0
        |-> rd_data[47:44] == 4'h1)
        else $error("activity monitor field wrong");

    a_part_field: assert property (@(posedge clk_sys) disable iff (!nrst)
        rd_valid && rd_hit && !rd_trap && rd_data != 64'h0
        |-> rd_data[43:40] == 4'h1)
        else $error("partitioning field wrong");

    a_secure_hyp: assert property (@(posedge clk_sys) disable iff (!nrst)
        rd_valid && rd_hit && !rd_trap && rd_data != 64'h0
        |-> rd_data[39:36] == 4'h1)
        else $error("secure hypervisor field wrong");

    a_vector_state: assert property (@(posedge clk_sys) disable iff (!nrst)
        rd_valid && rd_hit && !rd_trap && rd_data != 64'h0
        |-> rd_data[35:32] == 4'h1)
        else $error("scalable vector field wrong");

    a_reliab_field: assert property (@(posedge clk_sys) disable iff (!nrst)
        rd_valid && rd_hit && !rd_trap && rd_data != 64'h0
        |-> rd_data[31:28] == 4'h2)
        else $error("reliability field wrong");

    a_vector_unit: assert property (@(posedge clk_sys) disable iff (!nrst)
        rd_valid && rd_hit && !rd_trap && rd_data != 64'h0
        |-> rd_data[23:20] == 4'h1)
        else $error("vector unit field wrong");

    a_float_field: assert property (@(posedge clk_sys) disable iff (!nrst)
        rd_valid && rd_hit && !rd_trap && rd_data != 64'h0
        |-> rd_data[19:16] == 4'h1)
        else $error("floating point field wrong");

    a_mon_level: assert property (@(posedge clk_sys) disable iff (!nrst)
        rd_valid && rd_hit && !rd_trap && rd_data != 64'h0
        |-> rd_data[15:12] == 4'h1)
        else $error("monitor level field wrong");

    a_hyp_level: assert property (@(posedge clk_sys) disable iff (!nrst)
        rd_valid && rd_hit && !rd_trap && rd_data != 64'h0
        |-> rd_data[11:8] == 4'h1)
        else $error("hypervisor level field wrong");

    a_kern_level: assert property (@(posedge clk_sys) disable iff (!nrst)
        rd_valid && rd_hit && !rd_trap && rd_data != 64'h0
        |-> rd_data[7:4] == 4'h1)
        else $error("kernel level field wrong");

    a_user_level: assert property (@(posedge clk_sys) disable iff (!nrst)
        rd_valid && rd_hit && !rd_trap && rd_data != 64'h0
        |-> rd_data[3:0] == 4'h1)
        else $error("user level field wrong");

    // Fields above the timing field carry nothing
    a_upper_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
        rd_valid |-> rd_data[63:52] == 12'h0)
        else $error("upper fields not zero");

    // =========================================================
    // Trap routing
    a_user_to_hyp: assert property (@(posedge clk_sys) disable iff (!nrst)
        rd_req && current_exception_level == 2'h0 && hyp_enabled &&
        trap_general_exceptions_bit && rd_op2[2:1] == 2'h0 &&
        group_match(rd_op0, rd_op1, rd_crn, rd_crm)
        |=> rd_trap && rd_trap_level == 2'h2)
        else $error("user read not sent to hypervisor");

    a_user_to_kern: assert property (@(posedge clk_sys) disable iff (!nrst)
        rd_req && current_exception_level == 2'h0 &&
        !(hyp_enabled && trap_general_exceptions_bit) &&
        rd_op2[2:1] == 2'h0 && group_match(rd_op0, rd_op1, rd_crn, rd_crm)
        |=> rd_trap && rd_trap_level == 2'h1)
        else $error("user read not sent to kernel");

    a_user_no_data: assert property (@(posedge clk_sys) disable iff (!nrst)
        rd_req && current_exception_level == 2'h0
        |=> rd_data == 64'h0)
        else $error("user read leaked data");

    a_kern_returns: assert property (@(posedge clk_sys) disable iff (!nrst)
        rd_req && current_exception_level == 2'h1 &&
        !(hyp_enabled && trap_id_group3_bit) && rd_op2 == 3'h0 &&
        group_match(rd_op0, rd_op1, rd_crn, rd_crm)
        |=> rd_hit && !rd_trap && rd_data[51:48] == 4'h1)
        else $error("kernel read did not return value");

    a_pfr1_kernel: assert property (@(posedge clk_sys) disable iff (!nrst)
        rd_req && current_exception_level == 2'h1 &&
        !(hyp_enabled && trap_id_group3_bit) && rd_op2 == 3'h1 &&
        group_match(rd_op0, rd_op1, rd_crn, rd_crm)
        |=> rd_hit && !rd_trap && rd_data == 64'h0)
        else $error("second register kernel read wrong");

    a_trap_class: assert property (@(posedge clk_sys) disable iff (!nrst)
        rd_trap |-> rd_trap_class == 6'h18 && rd_data == 64'h0)
        else $error("trap class or data wrong");

    a_no_trap_quiet: assert property (@(posedge clk_sys) disable iff (!nrst)
        !rd_trap |-> rd_trap_class == 6'h0 && rd_trap_level == 2'h0)
        else $error("trap fields set without trap");

    // =========================================================
    // Decode
    a_hit_match: assert property (@(posedge clk_sys) disable iff (!nrst)
        rd_req && rd_op2[2:1] == 2'h0 &&
        group_match(rd_op0, rd_op1, rd_crn, rd_crm)
        |=> rd_hit)
        else $error("matching encoding missed");

    a_op2_miss: assert property (@(posedge clk_sys) disable iff (!nrst)
        rd_req && rd_op2[2:1] != 2'h0
        |=> !rd_hit && !rd_trap && rd_data == 64'h0)
        else $error("unused op2 answered");

    a_op0_miss: assert property (@(posedge clk_sys) disable iff (!nrst)
        rd_req && rd_op0 != 2'h3
        |=> !rd_hit && !rd_trap && rd_data == 64'h0)
        else $error("wrong op0 answered");

    a_op1_miss: assert property (@(posedge clk_sys) disable iff (!nrst)
        rd_req && rd_op1 != 3'h0
        |=> !rd_hit && !rd_trap && rd_data == 64'h0)
        else $error("wrong op1 answered");

    a_crn_miss: assert property (@(posedge clk_sys) disable iff (!nrst)
        rd_req && rd_crn != 4'h0
        |=> !rd_hit && !rd_trap && rd_data == 64'h0)
        else $error("wrong crn answered");

    a_hit_valid: assert property (@(posedge clk_sys) disable iff (!nrst)
        rd_hit |-> rd_valid)
        else $error("hit without valid");

    // =========================================================
    // Handshake, reset and strap
    a_answer_next: assert property (@(posedge clk_sys) disable iff (!nrst)
        rd_req |=> rd_valid)
        else $error("request not answered");

    // A read leaves nothing behind for the next cycle
    a_idle_quiet: assert property (@(posedge clk_sys) disable iff (!nrst)
        !rd_req |=> !rd_valid && !rd_hit && !rd_trap && rd_data == 64'h0)
        else $error("answer without request");

    // Not disabled by reset: it checks what reset does
    a_reset_clears: assert property (@(posedge clk_sys)
        !nrst |=> !rd_valid && !rd_hit && !rd_trap && rd_data == 64'h0)
        else $error("reset did not clear the answer");

    // Only the second stage may feed the feature word
    a_strap_sync: assert property (@(posedge clk_sys) disable iff (!nrst)
        $past(nrst) |-> st_r.dis_sync == $past(st_r.dis_meta))
        else $error("strap synchroniser skipped a stage");
endmodule
`default_nettype wire

// ### inc/feat_id_pkg.sv
// Constants and types for the processor feature identification block
`default_nettype none
package feat_id_pkg;
    // =========================================================
    // Encodings
    localparam logic [1:0] SEL_OP0        = 2'h3;
    localparam logic [2:0] SEL_OP1        = 3'h0;
    localparam logic [3:0] SEL_CRN        = 4'h0;
    localparam logic [3:0] SEL_CRM        = 4'h4;
    localparam logic [2:0] SEL_OP2_PFR0   = 3'h0;
    localparam logic [2:0] SEL_OP2_PFR1   = 3'h1;
    localparam logic [5:0] TRAP_CLASS     = 6'h18;
    // =========================================================
    // Field positions (low bit) and values
    localparam int         POS_TIMING     = 48;
    localparam int         POS_ACTMON     = 44;
    localparam int         POS_PARTMON    = 40;
    localparam int         POS_SHYP       = 36;
    localparam int         POS_SVEC       = 32;
    localparam int         POS_RAS        = 28;
    localparam int         POS_CPUIF      = 24;
    localparam int         POS_VEC        = 20;
    localparam int         POS_FLOAT      = 16;
    localparam int         POS_MON        = 12;
    localparam int         POS_HYP        = 8;
    localparam int         POS_KRN        = 4;
    localparam int         POS_USR        = 0;
    localparam logic [3:0] VAL_ONE        = 4'h1;
    localparam logic [3:0] VAL_RAS        = 4'h2;
    localparam logic [3:0] VAL_CPUIF_ON   = 4'h3;
    localparam logic [3:0] VAL_CPUIF_OFF  = 4'h0;
    localparam logic [63:0] PFR1_VALUE    = 64'h0;
    // =========================================================
    // Exception levels
    typedef enum logic [1:0] {
        LVL_USER = 2'h0,
        LVL_KERNEL = 2'h1,
        LVL_HYP = 2'h2,
        LVL_MON = 2'h3
    } level_t;
endpackage
`default_nettype wire

// ### hdl/feat_value.sv
// Combinational builder of the primary feature word
`default_nettype none
module feat_value
    import feat_id_pkg::*;
(
    // Strap input, already synchronised
    input  wire logic        cpu_if_disable,
    // Feature word
    output logic [63:0]      value
);
    always_comb begin
        value = '0;
        value[POS_TIMING  +: 4] = VAL_ONE;
        value[POS_ACTMON  +: 4] = VAL_ONE;
        value[POS_PARTMON +: 4] = VAL_ONE;
        value[POS_SHYP +: 4] = VAL_ONE;
        value[POS_SVEC +: 4] = VAL_ONE;
        value[POS_RAS  +: 4] = VAL_RAS;
        value[POS_CPUIF +: 4] = cpu_if_disable ? VAL_CPUIF_OFF
                                               : VAL_CPUIF_ON;
        value[POS_VEC  +: 4] = VAL_ONE;
        value[POS_FLOAT +: 4] = VAL_ONE;
        value[POS_MON  +: 4] = VAL_ONE;
        value[POS_HYP  +: 4] = VAL_ONE;
        value[POS_KRN  +: 4] = VAL_ONE;
        value[POS_USR  +: 4] = VAL_ONE;
    end
endmodule
`default_nettype wire

// ### sim/read_issuer.sv
// Pipeline model that issues system register reads to the block
`default_nettype none
module read_issuer (
    // Clock
    input  wire logic       clk_sys,
    // Read request towards the block
    output logic            rd_req,
    output logic [1:0]      rd_op0,
    output logic [2:0]      rd_op1,
    output logic [3:0]      rd_crn,
    output logic [3:0]      rd_crm,
    output logic [2:0]      rd_op2
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        rd_req = 1'h0;
        {rd_op0, rd_op1, rd_crn, rd_crm, rd_op2} = 16'h5a5a;
    end
    // Encoding held through the taking edge
    task automatic issue(input logic [15:0] enc);
        {rd_op0, rd_op1, rd_crn, rd_crm, rd_op2} = enc;
        rd_req = 1'h1;
        @(posedge clk_sys);
        #1;
    endtask
    // Released fields invert, so a stale encoding never looks valid
    task automatic idle();
        rd_req = 1'h0;
        {rd_op0, rd_op1, rd_crn, rd_crm, rd_op2} =
            ~{rd_op0, rd_op1, rd_crn, rd_crm, rd_op2};
    endtask
endmodule
`default_nettype wire

// ### sim/tb_processor_feature_id.sv
// Self-checking bench for the feature identification read port
`default_nettype none
module tb_processor_feature_id;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [63:0] ON  = 64'h0001_1111_2311_1111;
    localparam logic [63:0] OFF = 64'h0001_1111_2011_1111;
    typedef struct packed {
        logic [4:0]  ctx;
        logic [15:0] enc;
        logic [3:0]  res;
        logic [63:0] data;
    } row_t;
    logic clk_sys = 1'h0;
    logic nrst, strap, hyp, tge, tid3, rd_req;
    logic rd_valid, rd_hit, rd_trap;
    logic [1:0] lvl, rd_op0, rd_trap_level;
    logic [2:0] rd_op1, rd_op2;
    logic [3:0] rd_crn, rd_crm;
    logic [5:0] rd_trap_class;
    logic [63:0] rd_data;
    int errors = 0;
    int checked = 0;
    // ctx = level, hyp enable, general trap, group-3 trap
    row_t rows [10] = '{
        '{5'h17, 16'hc020, 4'h8, ON}, '{5'h1f, 16'hc020, 4'h8, ON},
        '{5'h06, 16'hc020, 4'he, 64'h0}, '{5'h02, 16'hc020, 4'hd, 64'h0},
        '{5'h04, 16'hc020, 4'hd, 64'h0}, '{5'h0d, 16'hc020, 4'he, 64'h0},
        '{5'h09, 16'hc020, 4'h8, ON}, '{5'h0e, 16'hc020, 4'h8, ON},
        '{5'h10, 16'hc021, 4'h8, 64'h0}, '{5'h10, 16'hc028, 4'h0, 64'h0}};
    always #10 clk_sys = ~clk_sys;
    read_issuer u_pipe (.clk_sys(clk_sys), .rd_req(rd_req),
        .rd_op0(rd_op0), .rd_op1(rd_op1), .rd_crn(rd_crn),
        .rd_crm(rd_crm), .rd_op2(rd_op2));
    processor_feature_id dut (.clk_sys(clk_sys), .nrst(nrst),
        .cpu_if_disable_input(strap), .current_exception_level(lvl),
        .hyp_enabled(hyp), .trap_general_exceptions_bit(tge),
        .trap_id_group3_bit(tid3), .rd_req(rd_req), .rd_op0(rd_op0),
        .rd_op1(rd_op1), .rd_crn(rd_crn), .rd_crm(rd_crm),
        .rd_op2(rd_op2), .rd_valid(rd_valid), .rd_data(rd_data),
        .rd_hit(rd_hit), .rd_trap(rd_trap), .rd_trap_level(rd_trap_level),
        .rd_trap_class(rd_trap_class));
    task automatic chk(input string nm, input logic [63:0] exp,
                       input logic [63:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // res = hit, trap, trap target level
    task automatic ans(input logic [3:0] res, input logic [63:0] d);
        chk("valid", 64'h1, rd_valid);
        chk("hit", res[3], rd_hit);
        chk("trap", res[2], rd_trap);
        chk("trap level", res[1:0], rd_trap_level);
        chk("class", res[2] ? 64'h18 : 64'h0, rd_trap_class);
        chk("data", d, rd_data);
        chk("low", d[23:0], rd_data[23:0]);
        chk("levels", d[15:0], rd_data[15:0]);
    endtask
    task automatic go(input row_t r);
        {lvl, hyp, tge, tid3} = r.ctx;
        u_pipe.issue(r.enc);
        ans(r.res, r.data);
        u_pipe.idle();
        @(posedge clk_sys);
        #1;
        chk("idle valid", 64'h0, rd_valid);
        chk("idle data", 64'h0, rd_data);
    endtask
    task automatic end_sim();
        $display("Counts: %0d checked, %0d errors", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #4000;
        errors++;
        end_sim();
    end
    initial begin
        {nrst, strap, lvl, hyp, tge, tid3} = 7'h0;
        repeat (10) @(posedge clk_sys);
        #1;
        chk("reset valid", 64'h0, rd_valid);
        nrst = 1'h1;
        repeat (3) @(posedge clk_sys);
        #1;
        foreach (rows[i]) begin
            go(rows[i]);
            $display("row %0d done", i);
        end
        // Back to back: a trap between two reads leaves no trace
        {lvl, hyp, tge, tid3} = 5'h17;
        u_pipe.issue(16'hc020);
        ans(4'h8, ON);
        {lvl, hyp, tge, tid3} = 5'h06;
        u_pipe.issue(16'hc020);
        ans(4'he, 64'h0);
        {lvl, hyp, tge, tid3} = 5'h17;
        u_pipe.issue(16'hc020);
        ans(4'h8, ON);
        u_pipe.idle();
        @(posedge clk_sys);
        #1;
        $display("back to back done");
        // Strap is synchronised, so allow it three edges
        strap = 1'h1;
        repeat (3) @(posedge clk_sys);
        #1;
        go('{5'h10, 16'hc020, 4'h8, OFF});
        strap = 1'h0;
        repeat (3) @(posedge clk_sys);
        #1;
        go('{5'h10, 16'hc020, 4'h8, ON});
        $display("strap done");
        // Reset in mid-run swallows a standing request
        {lvl, hyp, tge, tid3} = 5'h10;
        nrst = 1'h0;
        u_pipe.issue(16'hc020);
        chk("mid reset valid", 64'h0, rd_valid);
        chk("mid reset data", 64'h0, rd_data);
        chk("mid reset hit", 64'h0, rd_hit);
        u_pipe.idle();
        nrst = 1'h1;
        @(posedge clk_sys);
        #1;
        chk("release valid", 64'h0, rd_valid);
        go('{5'h10, 16'hc020, 4'h8, ON});
        $display("mid reset done");
        end_sim();
    end
endmodule
`default_nettype wire
